// ===== hw/csc_regs.svh
// Register offsets, write masks, reset values and field codes of the status and cause block.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the bus
// ----------------------------------------------------------------------
`define CSC_STATUS_ADDR 32'h0000_0030
`define CSC_CAUSE_ADDR 32'h0000_0034

// ----------------------------------------------------------------------
// Software write masks (1 = software may change the bit)
// ----------------------------------------------------------------------
`define CSC_STATUS_WMASK 32'hFFDF_FFFF
`define CSC_CAUSE_WMASK 32'h0000_0300

// ----------------------------------------------------------------------
// Reset values: error level and boot vector select set, all else clear
// ----------------------------------------------------------------------
`define CSC_STATUS_RESET 32'h0040_0004
`define CSC_CAUSE_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Privilege mode field codes and the unusable-coprocessor code
// ----------------------------------------------------------------------
`define CSC_KSU_KERNEL 2'h0
`define CSC_KSU_SUPER 2'h1
`define CSC_KSU_USER 2'h2
`define CSC_CODE_COP_UNUSABLE 5'h0B

`endif

// ===== hw/csc_pkg.sv
// Types shared by the status and cause register block.
package csc_pkg;

	// ------------------------------------------------------------------
	// Processor status register layout, most significant bit first.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] coprocessorUsableBits;
		logic rsv27;
		logic floatRegCountSelect;
		logic rsv25;
		logic debugEntryEnable;
		logic rsv23;
		logic bootVectorSelect;
		logic tlbShutdownFlag;
		logic softResetFlag;
		logic rsv19;
		logic cp0ConditionFlag;
		logic parityInjectEnable;
		logic rsv16;
		logic [7:0] interruptMaskBits;
		logic kernelWideAddressing;
		logic supervisorWideAddressing;
		logic userWideAddressing;
		logic [1:0] privilegeModeField;
		logic errorLevel;
		logic exceptionLevel;
		logic globalInterruptEnable;
	} csc_status_t;

	// ------------------------------------------------------------------
	// Exception cause register layout; the zero fields always read 0.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic branchDelayFlag;
		logic zero30;
		logic [1:0] copUnitNumber;
		logic [11:0] zero27to16;
		logic [7:0] interruptPendingBits;
		logic zero7;
		logic [4:0] exceptionCodeField;
		logic [1:0] zero1to0;
	} csc_cause_t;

	// ------------------------------------------------------------------
	// Exception codes; values not listed are reserved.
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		EXC_INT = 5'h00, EXC_MOD = 5'h01, EXC_TLB_LOAD = 5'h02, EXC_TLB_STORE = 5'h03,
		EXC_ADDR_LOAD = 5'h04, EXC_ADDR_STORE = 5'h05, EXC_BUS_FETCH = 5'h06,
		EXC_BUS_DATA = 5'h07, EXC_SYSCALL = 5'h08, EXC_BREAK = 5'h09, EXC_RSVD_INSTR = 5'h0A,
		EXC_COP_UNUSABLE = 5'h0B, EXC_OVERFLOW = 5'h0C, EXC_TRAP = 5'h0D,
		EXC_FLOAT = 5'h0F, EXC_WATCH = 5'h17
	} csc_exc_code_t;

	// ------------------------------------------------------------------
	// Exception report from the pipeline, valid while take is high.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic take;
		logic errorClass;
		logic softReset;
		csc_exc_code_t code;
		logic delaySlot;
		logic [1:0] copNumber;
	} csc_exc_t;

	// Bus slave states.
	typedef enum logic {
		WB_IDLE = 1'b0,
		WB_ACK = 1'b1
	} csc_wb_state_t;

endpackage

// ===== hw/csc_status_cause.sv
// Processor status and exception cause registers with a classic Wishbone slave.
`timescale 1ns/1ns
`include "csc_regs.svh"
module csc_status_cause (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire csc_pkg::csc_exc_t exc,
	input wire logic eretTake,
	input wire logic tlbMultiMatch,
	input wire logic [4:0] extIntLines,
	input wire logic [4:0] sysBusIntSet,
	input wire logic [4:0] sysBusIntClear,
	input wire logic timerMatch,
	input wire logic counterOverflow,
	input wire logic compareWrite,
	input wire logic [7:0] parityPattern,
	input wire logic [7:0] computedParity,
	output logic intRequest,
	output logic kernelMode,
	output logic supervisorMode,
	output logic userMode,
	output logic wideOps,
	output logic wideAddr,
	output logic extIsaEnable,
	output logic floatRegs32,
	output logic [3:0] copUsable,
	output logic debugEnable,
	output logic bootVectors,
	output logic useErrorReturn,
	output logic userUnmapped,
	output logic refillGeneral,
	output logic returnAddrWrite,
	output logic tlbDisabled,
	output logic [7:0] parityOut
);
	import csc_pkg::*;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Merges write data into a register by byte enables and write mask.
	function automatic logic [31:0] mergeWrite(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel, input logic [31:0] wmask);
		logic [31:0] laneMask;
		laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
		return (old & ~laneMask) | (wdat & laneMask);
	endfunction

	// Kernel mode holds when the field says so or either level is set.
	function automatic logic isKernel(input csc_status_t s);
		return (s.privilegeModeField == `CSC_KSU_KERNEL) || s.exceptionLevel || s.errorLevel;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	csc_wb_state_t wbState; // Bus slave state.
	csc_status_t status; // Processor status register.
	csc_cause_t cause; // Exception cause register.
	csc_status_t next_status; // Status after writes and events.
	csc_cause_t next_cause; // Cause after writes and events.
	logic timerPending; // Sticky timer or overflow pending.
	logic [4:0] sysBusPending; // Sticky pending set over the shared system bus.
	logic busWrite; // A write completes at this edge.
	logic [31:0] readMux; // Read data for the addressed register.

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------

	// Write takes effect at the edge where the master samples ack high.
	assign busWrite = (wbState == WB_ACK) && wb_cyc_i && wb_stb_i && wb_we_i;

	// Read data; unmapped addresses read as zero.
	always_comb begin
		case (wb_adr_i)
			`CSC_STATUS_ADDR: readMux = status;
			`CSC_CAUSE_ADDR: readMux = cause;
			default: readMux = 32'h0000_0000;
		endcase
	end

	// One-cycle ack one cycle after the request, then one idle cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wbState <= WB_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			case (wbState)
				WB_IDLE: begin
					if (wb_cyc_i && wb_stb_i) begin
						wbState <= WB_ACK;
						wb_ack_o <= 1'b1;
						wb_dat_o <= readMux;
					end
				end
				WB_ACK: begin
					wbState <= WB_IDLE;
					wb_ack_o <= 1'b0;
				end
				default: begin
					wbState <= WB_IDLE;
					wb_ack_o <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Status register next value: software first, hardware wins
	// ------------------------------------------------------------------
	always_comb begin
		next_status = status;
		// The condition flag and reserved bits are plain storage.
		if (busWrite && (wb_adr_i == `CSC_STATUS_ADDR)) begin
			next_status = mergeWrite(status, wb_dat_i, wb_sel_i, `CSC_STATUS_WMASK);
		end
		// Return from exception drops the innermost level.
		if (eretTake) begin
			if (status.errorLevel) begin
				next_status.errorLevel = 1'b0;
			end else begin
				next_status.exceptionLevel = 1'b0;
			end
		end
		// Exception entry sets the level that belongs to its class.
		if (exc.take) begin
			if (exc.errorClass) begin
				next_status.errorLevel = 1'b1;
			end else begin
				next_status.exceptionLevel = 1'b1;
			end
			if (exc.softReset) begin
				next_status.softResetFlag = 1'b1;
			end
		end
		// Shutdown is read only and cleared by reset alone.
		if (tlbMultiMatch) begin
			next_status.tlbShutdownFlag = 1'b1;
		end
	end

	// Status register storage.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status <= `CSC_STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// ------------------------------------------------------------------
	// Pending sources
	// ------------------------------------------------------------------

	// Timer and overflow pending; a new event beats a compare write.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timerPending <= 1'b0;
		end else if (timerMatch || counterOverflow) begin
			timerPending <= 1'b1;
		end else if (compareWrite) begin
			timerPending <= 1'b0;
		end
	end

	// Shared system bus pending bits; a set beats a clear.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sysBusPending <= 5'h00;
		end else begin
			sysBusPending <= (sysBusPending & ~sysBusIntClear) | sysBusIntSet;
		end
	end

	// ------------------------------------------------------------------
	// Cause register next value
	// ------------------------------------------------------------------
	always_comb begin
		next_cause = cause;
		// Only the software pending bits take bus writes.
		if (busWrite && (wb_adr_i == `CSC_CAUSE_ADDR)) begin
			next_cause = mergeWrite(cause, wb_dat_i, wb_sel_i, `CSC_CAUSE_WMASK);
		end
		// Hardware pending bits follow their sources.
		next_cause.interruptPendingBits[7] = timerPending;
		next_cause.interruptPendingBits[6:2] = extIntLines | sysBusPending;
		// Exception entry records code and delay slot, and the unit number for a coprocessor-unusable code.
		if (exc.take) begin
			next_cause.exceptionCodeField = exc.code;
			next_cause.branchDelayFlag = exc.delaySlot;
			if (exc.code == `CSC_CODE_COP_UNUSABLE) begin
				next_cause.copUnitNumber = exc.copNumber;
			end
		end
	end

	// Cause register storage.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cause <= `CSC_CAUSE_RESET;
		end else begin
			cause <= next_cause;
		end
	end

	// ------------------------------------------------------------------
	// Decoded controls, registered from the current register state
	// ------------------------------------------------------------------

	// Interrupt request and privilege mode.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			intRequest <= 1'b0;
			kernelMode <= 1'b1;
			supervisorMode <= 1'b0;
			userMode <= 1'b0;
		end else begin
			intRequest <= status.globalInterruptEnable && !status.exceptionLevel &&
				!status.errorLevel &&
				|(cause.interruptPendingBits & status.interruptMaskBits);
			kernelMode <= isKernel(status);
			supervisorMode <= !isKernel(status) &&
				(status.privilegeModeField == `CSC_KSU_SUPER);
			userMode <= !isKernel(status) &&
				(status.privilegeModeField == `CSC_KSU_USER);
		end
	end

	// Width, coprocessor and vector controls.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wideOps <= 1'b1;
			wideAddr <= 1'b0;
			extIsaEnable <= 1'b0;
			floatRegs32 <= 1'b0;
			copUsable <= 4'h1;
			debugEnable <= 1'b0;
			bootVectors <= 1'b1;
		end else begin
			if (isKernel(status)) begin
				wideOps <= 1'b1;
				wideAddr <= status.kernelWideAddressing;
			end else if (status.privilegeModeField == `CSC_KSU_SUPER) begin
				wideOps <= status.supervisorWideAddressing;
				wideAddr <= status.supervisorWideAddressing;
			end else begin
				wideOps <= status.userWideAddressing;
				wideAddr <= status.userWideAddressing;
			end
			extIsaEnable <= status.coprocessorUsableBits[3];
			floatRegs32 <= status.floatRegCountSelect;
			copUsable <= status.coprocessorUsableBits | {3'h0, isKernel(status)};
			debugEnable <= status.debugEntryEnable;
			bootVectors <= status.bootVectorSelect;
		end
	end

	// Level effects, shutdown and parity injection.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			useErrorReturn <= 1'b1;
			userUnmapped <= 1'b1;
			refillGeneral <= 1'b0;
			returnAddrWrite <= 1'b1;
			tlbDisabled <= 1'b0;
			parityOut <= 8'h00;
		end else begin
			useErrorReturn <= status.errorLevel;
			userUnmapped <= status.errorLevel;
			refillGeneral <= status.exceptionLevel;
			returnAddrWrite <= !status.exceptionLevel;
			tlbDisabled <= status.tlbShutdownFlag;
			parityOut <= status.parityInjectEnable ? parityPattern : computedParity;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_INT_LEVELS: assert property ((status.exceptionLevel || status.errorLevel) |=> !intRequest)
		else $error("interrupt raised while a level is set");
	AST_INT_MASKED: assert property ((cause.interruptPendingBits & status.interruptMaskBits) == 8'h00
		|=> !intRequest)
		else $error("interrupt raised with nothing unmasked");
	AST_KERNEL_LEVEL: assert property ((status.errorLevel || status.exceptionLevel)
		|=> kernelMode && !userMode && !supervisorMode && copUsable[0] && wideOps)
		else $error("kernel mode not forced by level");
	AST_ERL_SET: assert property (exc.take && exc.errorClass |=> status.errorLevel ##1
		(useErrorReturn && !intRequest))
		else $error("error level entry failed");
	AST_EXL_SET: assert property (exc.take && !exc.errorClass && !eretTake |=> status.exceptionLevel
		##1 !returnAddrWrite)
		else $error("exception level entry failed");
	AST_TS_STICKY: assert property (tlbMultiMatch |=> status.tlbShutdownFlag [*8])
		else $error("shutdown flag not sticky");
	AST_SR_SET: assert property (exc.take && exc.softReset |=> status.softResetFlag)
		else $error("soft reset flag not set");
	AST_TIMER_IP: assert property (timerMatch |=> ##1 cause.interruptPendingBits[7])
		else $error("timer pending not set");
	AST_CODE_HOLD: assert property (!exc.take |=> $stable(cause.exceptionCodeField) &&
		$stable(cause.branchDelayFlag))
		else $error("read-only cause field changed");
	AST_BD_TRACK: assert property (exc.take |=> cause.branchDelayFlag == $past(exc.delaySlot))
		else $error("branch delay flag wrong");
	AST_PARITY: assert property (status.parityInjectEnable |=> parityOut == $past(parityPattern))
		else $error("parity pattern not injected");

	COV_INT: cover property (intRequest);
	COV_ERR_ENTRY: cover property (exc.take && exc.errorClass ##1 status.errorLevel);
	COV_SHUTDOWN: cover property (tlbMultiMatch ##1 status.tlbShutdownFlag);
	COV_WRITE: cover property (busWrite && (wb_adr_i == `CSC_CAUSE_ADDR));

endmodule // csc_status_cause

// ===== testbench/csc_status_cause_tb.sv
// Self-checking bench for the status and cause register block.
`timescale 1ns/1ns
`include "csc_regs.svh"
module csc_status_cause_tb;
	import csc_pkg::*;
	// ------------------------------------------------------------------
	// Stimulus, outputs and bench state
	// ------------------------------------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	csc_exc_t exc = '0;
	logic eretTake = 1'b0;
	logic tlbMultiMatch = 1'b0;
	logic [4:0] extIntLines = 5'h0;
	logic [4:0] sysBusIntSet = 5'h0;
	logic [4:0] sysBusIntClear = 5'h0;
	logic timerMatch = 1'b0;
	logic counterOverflow = 1'b0;
	logic compareWrite = 1'b0;
	logic [7:0] parityPattern = 8'h0;
	logic [7:0] computedParity = 8'h0;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	wire [26:0] dec; // Decoded outputs side by side, intRequest on top.
	logic [31:0] seed = 32'h01103768;
	logic [31:0] stw = `CSC_STATUS_RESET; // Expected status contents.
	logic [7:0] ip = 8'h0; // Expected pending bits.
	logic [1:0] cop = 2'h0; // Expected coprocessor number.
	logic probe = 1'b0; // Marks the cycle in which the decoded outputs are judged.
	logic [31:0] rdQ [$];
	logic [26:0] decQ [$];
	int failCount = 0;
	int testsRun = 0;
	logic [4:0] codes [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h17};

	csc_status_cause uut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .exc(exc), .eretTake(eretTake),
		.tlbMultiMatch(tlbMultiMatch), .extIntLines(extIntLines), .sysBusIntSet(sysBusIntSet),
		.sysBusIntClear(sysBusIntClear), .timerMatch(timerMatch),
		.counterOverflow(counterOverflow), .compareWrite(compareWrite),
		.parityPattern(parityPattern), .computedParity(computedParity),
		.intRequest(dec[26]), .kernelMode(dec[25]), .supervisorMode(dec[24]),
		.userMode(dec[23]), .wideOps(dec[22]), .wideAddr(dec[21]), .extIsaEnable(dec[20]),
		.floatRegs32(dec[19]), .copUsable(dec[18:15]), .debugEnable(dec[14]),
		.bootVectors(dec[13]), .useErrorReturn(dec[12]), .userUnmapped(dec[11]),
		.refillGeneral(dec[10]), .returnAddrWrite(dec[9]), .tlbDisabled(dec[8]),
		.parityOut(dec[7:0]));

	// The clock toggles every 25 ns, a period of 50 ns.
	always #25 clk = ~clk;

	// ------------------------------------------------------------------
	// Helpers: random source, expected decode, verdict
	// ------------------------------------------------------------------
	// Xorshift source from a fixed seed.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Works out every decoded output from the modelled status and pending bits.
	function automatic logic [26:0] expDec(input csc_status_t s, input logic [7:0] p);
		logic k;
		logic sv;
		logic u;
		k = (s.privilegeModeField == `CSC_KSU_KERNEL) || s.exceptionLevel || s.errorLevel;
		sv = !k && (s.privilegeModeField == `CSC_KSU_SUPER);
		u = !k && (s.privilegeModeField == `CSC_KSU_USER);
		return {s.globalInterruptEnable && !s.exceptionLevel && !s.errorLevel
			&& (|(p & s.interruptMaskBits)), k, sv, u,
			k || (sv && s.supervisorWideAddressing) || (u && s.userWideAddressing),
			k ? s.kernelWideAddressing : (sv ? s.supervisorWideAddressing : s.userWideAddressing),
			s.coprocessorUsableBits[3], s.floatRegCountSelect, s.coprocessorUsableBits | {3'h0, k},
			s.debugEntryEnable, s.bootVectorSelect, s.errorLevel, s.errorLevel, s.exceptionLevel,
			!s.exceptionLevel, s.tlbShutdownFlag,
			s.parityInjectEnable ? parityPattern : computedParity};
	endfunction

	// Prints the verdict and ends the run.
	task automatic wrapUp();
		if (failCount == 0 && testsRun > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Bus master and checks
	// ------------------------------------------------------------------
	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
		input logic [3:0] sel);
		int n;
		repeat (3) @(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			failCount++;
			$display("mismatch at %0t: no bus answer", $time);
			wrapUp();
		end
	endtask

	// Read with its expected word noted first.
	task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
		rdQ.push_back(exp);
		wb(1'b0, adr, 32'h0, 4'hF);
	endtask

	// Status write that also updates the model through the byte enables.
	// Software keeps bits 27, 25, 23 and 19 at 0 and bit 16 at 1.
	task automatic wrSt(input logic [31:0] v, input logic [3:0] sel);
		logic [31:0] m;
		logic [31:0] w;
		m = `CSC_STATUS_WMASK & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		w = (v & ~32'h0A88_0000) | 32'h0001_0000;
		wb(1'b1, `CSC_STATUS_ADDR, w, sel);
		stw = (w & m) | (stw & ~m);
	endtask

	// Notes the expected decode and marks one cycle after outputs have settled.
	task automatic chk();
		repeat (4) @(posedge clk);
		decQ.push_back(expDec(stw, ip));
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
	endtask

	task automatic cmpWord(input logic [31:0] exp);
		testsRun++;
		if (wb_dat_o !== exp) begin
			failCount++;
			$display("mismatch at %0t: read %h expected %h", $time, wb_dat_o, exp);
		end
	endtask

	task automatic cmpDec(input logic [26:0] exp);
		testsRun++;
		if (dec !== exp) begin
			failCount++;
			$display("mismatch at %0t: outputs %h expected %h", $time, dec, exp);
		end
	endtask

	// Watcher: takes the oldest note whenever a result shows at the ports.
	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rdQ.size() > 0)
			cmpWord(rdQ.pop_front());
		if (probe === 1'b1 && decQ.size() > 0)
			cmpDec(decQ.pop_front());
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [31:0] r;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd(`CSC_STATUS_ADDR, `CSC_STATUS_RESET);
		rd(`CSC_CAUSE_ADDR, `CSC_CAUSE_RESET);
		chk();
		// An unmapped place reads zero and ignores writes.
		wb(1'b1, 32'h0000_0038, 32'hFFFF_FFFF, 4'hF);
		rd(32'h0000_0038, 32'h0);
		// Every read-only field except the zero-marked bits is written with ones; those are written 0.
		wb(1'b1, `CSC_CAUSE_ADDR, 32'hB000_FF7C, 4'hF);
		ip = 8'h03;
		rd(`CSC_CAUSE_ADDR, 32'h0000_0300);
		// Random status contents, byte enables and parity levels.
		for (int i = 0; i < 12; i++) begin
			v = xs();
			r = xs();
			if (v[4:3] == 2'h3)
				v[4] = 1'b0;
			parityPattern <= r[7:0];
			computedParity <= r[15:8];
			wrSt(v, r[19:16] | 4'h1);
			rd(`CSC_STATUS_ADDR, stw);
			chk();
		end
		wb(1'b1, `CSC_CAUSE_ADDR, 32'h0, 4'hF);
		ip = 8'h0;
		// Pending sources and masking.
		wrSt(32'h0000_8001, 4'hF);
		@(posedge clk);
		timerMatch <= 1'b1;
		@(posedge clk);
		timerMatch <= 1'b0;
		ip = 8'h80;
		rd(`CSC_CAUSE_ADDR, {16'h0, ip, 8'h0});
		chk();
		compareWrite <= 1'b1;
		@(posedge clk);
		compareWrite <= 1'b0;
		ip = 8'h00;
		rd(`CSC_CAUSE_ADDR, {16'h0, ip, 8'h0});
		chk();
		counterOverflow <= 1'b1;
		@(posedge clk);
		counterOverflow <= 1'b0;
		ip = 8'h80;
		rd(`CSC_CAUSE_ADDR, {16'h0, ip, 8'h0});
		compareWrite <= 1'b1;
		extIntLines <= 5'h15;
		@(posedge clk);
		compareWrite <= 1'b0;
		ip = 8'h54;
		rd(`CSC_CAUSE_ADDR, {16'h0, ip, 8'h0});
		chk();
		wrSt(32'h0000_5401, 4'hF);
		chk();
		wrSt(32'h0000_5403, 4'hF);
		chk();
		extIntLines <= 5'h0;
		sysBusIntSet <= 5'h0A;
		@(posedge clk);
		sysBusIntSet <= 5'h0;
		ip = 8'h28;
		rd(`CSC_CAUSE_ADDR, {16'h0, ip, 8'h0});
		sysBusIntClear <= 5'h0A;
		@(posedge clk);
		sysBusIntClear <= 5'h0;
		ip = 8'h00;
		rd(`CSC_CAUSE_ADDR, {16'h0, ip, 8'h0});
		// Every exception code, then a return.
		wrSt(32'h0, 4'hF);
		for (int i = 0; i < 16; i++) begin
			r = xs();
			exc <= {1'b1, 1'b0, 1'b0, csc_exc_code_t'(codes[i]), r[0], r[2:1]};
			@(posedge clk);
			exc <= '0;
			if (codes[i] == `CSC_CODE_COP_UNUSABLE)
				cop = r[2:1];
			stw[1] = 1'b1;
			rd(`CSC_CAUSE_ADDR, {r[0], 1'b0, cop, 12'h0, ip, 1'b0, codes[i], 2'h0});
			rd(`CSC_STATUS_ADDR, stw);
			chk();
			eretTake <= 1'b1;
			@(posedge clk);
			eretTake <= 1'b0;
			stw[1] = 1'b0;
		end
		// Error-class exception with soft reset.
		exc <= {1'b1, 1'b1, 1'b1, EXC_INT, 1'b0, 2'h0};
		@(posedge clk);
		exc <= '0;
		stw[2] = 1'b1;
		stw[20] = 1'b1;
		rd(`CSC_STATUS_ADDR, stw);
		chk();
		// A return while the error level is set drops that level first.
		eretTake <= 1'b1;
		@(posedge clk);
		eretTake <= 1'b0;
		stw[2] = 1'b0;
		rd(`CSC_STATUS_ADDR, stw);
		// Sticky shutdown survives software writes.
		tlbMultiMatch <= 1'b1;
		@(posedge clk);
		tlbMultiMatch <= 1'b0;
		stw[21] = 1'b1;
		wrSt(32'h0, 4'hF);
		rd(`CSC_STATUS_ADDR, stw);
		chk();
		// Reset again in mid-run.
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		stw = `CSC_STATUS_RESET;
		ip = 8'h0;
		rd(`CSC_STATUS_ADDR, `CSC_STATUS_RESET);
		chk();
		repeat (3) @(posedge clk);
		wrapUp();
	end
endmodule // csc_status_cause_tb
